// ==== rcms_reset_control.sv ====
// Reset source classification, reset line drive and reset-time mode latch
// How it works
// - Any reset aborts processing; master reset wins over all other activity.
// - Synchronous resets wait for the current bus cycle to close.
// - Four lines driven: pin, clock unit, master, instruction reset.
// - All resets gated by output clock; asynchronous ones assert immediately.
// - Synchronous reset forces the bus monitor on to end a stuck cycle.
// - Power, watchdog, halt async; external, clock loss sync; test omits clock reset.
// - Reset instruction is asynchronous and drives only the pin and instruction reset lines.
// - Byte and aligned word writes under way finish before synchronous reset.
// - Data lines high select defaults, low select alternates.
// - First bus cycle starts ten output clocks after reset release.
// - Data 0 low gives eight-bit boot port, high gives sixteen-bit.
// - Boot select active at release; vectors fetched from address zero.
// - Data 1 low gives arbitration pins; data 2 low gives function codes.
// - Data 3 to 7 low turn chip-selects down to 6 into address lines.
// - Data 8 low gives strobe, acknowledge and size pins to port E.
// - Data 9 low gives interrupt and clock-mode pins to port F.
// - Data 11 low enables factory test mode.
// - Clock-mode pin high selects synthesizer; low selects external clock.
// - Either breakpoint low at release sets the background debug flag.
// - Both breakpoints high at release select breakpoint exceptions.
// - External reset input synchronised and taken only with clock running.
// - Pin reset held 512 output clocks after the outside lets go.
`timescale 1ns/100ps
module rcms_reset_control #(
    parameter int unsigned STRETCH = rcms_pkg::STRETCH_CYCLES,
    parameter int unsigned FIRST_DELAY = rcms_pkg::FIRST_CYCLE_DELAY
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic output_clock,
    input wire logic ext_reset_n,
    input wire logic power_up_req,
    input wire logic watchdog_req,
    input wire logic halt_req,
    input wire logic clock_loss_req,
    input wire logic test_req,
    input wire logic instr_req,
    input wire logic bus_cycle_end,
    input wire logic [15:0] data_in,
    input wire logic clock_source_pin,
    input wire logic breakpoint_in_int,
    input wire logic breakpoint_in,
    output logic pin_reset_drive,
    output logic clock_unit_reset,
    output logic master_reset_line,
    output logic instruction_reset_line,
    output logic bus_monitor_force,
    output logic bus_start,
    output logic boot_select,
    output logic [23:0] boot_vector_addr,
    output logic boot_port_8bit,
    output logic arbitration_pins,
    output logic function_code_pins,
    output logic [4:0] addr_pins,
    output logic general_port_e,
    output logic general_port_f,
    output logic test_mode,
    output logic synth_clock,
    output logic background_debug
);
    typedef enum logic [3:0] {
        RCMS_RUN = 4'h1,
        RCMS_WAIT = 4'h2,
        RCMS_RESET = 4'h4,
        RCMS_START = 4'h8
    } rcms_state_t;

    rcms_state_t state;
    rcms_state_t next_state;
    logic ext_meta, ext_sync, clk_prev, tick, cycle_tick;
    logic [6:0] pend, next_pend;
    logic mst, clk_r, ext_r, sys_r;
    logic next_mst, next_clk_r, next_ext_r, next_sys_r;
    logic [3:0] delay, next_delay;
    logic cfg_take;
    logic next_boot_port_8bit, next_arbitration_pins, next_function_code_pins;
    logic [4:0] next_addr_pins;
    logic next_general_port_e, next_general_port_f, next_test_mode;
    logic next_synth_clock, next_background_debug;
    logic stretch_active;
    logic [6:0] src;
    logic async_any, sync_any;

    // Output-clock edge detect; both edges count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            ext_meta <= ~ext_reset_n;
            ext_sync <= ext_meta;
            clk_prev <= output_clock;
        end
    end
    assign tick = output_clock ^ clk_prev;
    // Counts run in whole output-clock cycles, so only rising edges
    assign cycle_tick = output_clock & ~clk_prev;

    always_comb begin
        src = '0;
        src[rcms_pkg::SRC_POWER] = power_up_req;
        src[rcms_pkg::SRC_WATCHDOG] = watchdog_req;
        src[rcms_pkg::SRC_HALT] = halt_req;
        src[rcms_pkg::SRC_EXTERNAL] = ext_sync;
        src[rcms_pkg::SRC_CLOCK_LOSS] = clock_loss_req;
        src[rcms_pkg::SRC_TEST] = test_req;
        src[rcms_pkg::SRC_INSTR] = instr_req;
    end

    assign async_any = src[rcms_pkg::SRC_POWER] | src[rcms_pkg::SRC_WATCHDOG]
        | src[rcms_pkg::SRC_HALT];
    assign sync_any = src[rcms_pkg::SRC_EXTERNAL] | src[rcms_pkg::SRC_CLOCK_LOSS]
        | src[rcms_pkg::SRC_TEST];

    // Holds pin reset for the minimum count after all sources except the reset instruction drop
    rcms_stretch #(
        .CYCLES(STRETCH)
    ) u_stretch (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(cycle_tick),
        .hold(state == RCMS_WAIT || async_any || src[rcms_pkg::SRC_EXTERNAL]
            || src[rcms_pkg::SRC_CLOCK_LOSS] || src[rcms_pkg::SRC_TEST]),
        .active(stretch_active)
    );

    always_comb begin
        next_state = state;
        next_pend = pend;
        next_mst = mst;
        next_clk_r = clk_r;
        next_ext_r = ext_r;
        next_sys_r = sys_r;
        next_delay = delay;
        cfg_take = 1'b0;
        unique case (state)
            RCMS_RUN: begin
                if (tick && async_any) begin
                    // Immediate on any output-clock edge
                    next_mst = 1'b1;
                    next_clk_r = 1'b1;
                    next_ext_r = 1'b1;
                    next_state = RCMS_RESET;
                end else if (tick && sync_any) begin
                    next_pend = src;
                    next_state = RCMS_WAIT;
                end else if (tick && src[rcms_pkg::SRC_INSTR]) begin
                    next_ext_r = 1'b1;
                    next_sys_r = 1'b1;
                    next_state = RCMS_RESET;
                end
            end
            RCMS_WAIT: begin
                next_pend = pend | src;
                if (tick && async_any) begin
                    next_mst = 1'b1;
                    next_clk_r = 1'b1;
                    next_ext_r = 1'b1;
                    next_state = RCMS_RESET;
                end else if (tick && bus_cycle_end) begin
                    // Writes under way finish first
                    next_mst = 1'b1;
                    next_ext_r = 1'b1;
                    next_clk_r = pend[rcms_pkg::SRC_EXTERNAL]
                        | pend[rcms_pkg::SRC_CLOCK_LOSS];
                    next_state = RCMS_RESET;
                end
            end
            RCMS_RESET: begin
                if (tick && async_any && !mst) begin
                    // A catastrophic source overrides an instruction reset
                    next_mst = 1'b1;
                    next_clk_r = 1'b1;
                    next_ext_r = 1'b1;
                    next_sys_r = 1'b0;
                end else if (tick && !stretch_active && sys_r && !instr_req) begin
                    next_ext_r = 1'b0;
                    next_sys_r = 1'b0;
                    next_state = RCMS_RUN;
                end else if (tick && !stretch_active && !sys_r) begin
                    cfg_take = 1'b1;
                    next_mst = 1'b0;
                    next_clk_r = 1'b0;
                    next_ext_r = 1'b0;
                    next_pend = '0;
                    next_delay = 4'(FIRST_DELAY);
                    next_state = RCMS_START;
                end
            end
            RCMS_START: begin
                if (tick && async_any) begin
                    next_mst = 1'b1;
                    next_clk_r = 1'b1;
                    next_ext_r = 1'b1;
                    next_state = RCMS_RESET;
                end else if (cycle_tick && delay != 4'h0) begin
                    next_delay = delay - 4'h1;
                end else if (delay == 4'h0) begin
                    next_state = RCMS_RUN;
                end
            end
            default: next_state = RCMS_RESET;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RCMS_RESET;
            pend <= '0;
            mst <= 1'b1;
            clk_r <= 1'b1;
            ext_r <= 1'b1;
            sys_r <= 1'b0;
            delay <= 4'h0;
        end else begin
            state <= next_state;
            pend <= next_pend;
            mst <= next_mst;
            clk_r <= next_clk_r;
            ext_r <= next_ext_r;
            sys_r <= next_sys_r;
            delay <= next_delay;
        end
    end

    assign pin_reset_drive = ext_r;
    assign clock_unit_reset = clk_r;
    assign master_reset_line = mst;
    assign instruction_reset_line = sys_r;
    assign bus_monitor_force = (state == RCMS_WAIT);
    assign bus_start = (state == RCMS_START) && (delay == 4'h0);
    assign boot_select = !mst;
    assign boot_vector_addr = rcms_pkg::BOOT_VECTOR_ADDR;

    // A mode line pulled low selects the alternate function
    function automatic logic alt_sel(input logic [15:0] word, input int unsigned pos);
        return !word[pos];
    endfunction

    // Highest low line among data 3 to 7 sets the span down to chip-select 6
    function automatic logic [4:0] addr_span(input logic [15:0] word);
        logic [4:0] span;
        span = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (alt_sel(word, rcms_pkg::SEL_ADDR_LO + i)) begin
                span = 5'((6'h02 << i) - 6'h01);
            end
        end
        return span;
    endfunction

    // Mode pins caught once at release, held until the next reset
    always_comb begin
        next_boot_port_8bit = boot_port_8bit;
        next_arbitration_pins = arbitration_pins;
        next_function_code_pins = function_code_pins;
        next_addr_pins = addr_pins;
        next_general_port_e = general_port_e;
        next_general_port_f = general_port_f;
        next_test_mode = test_mode;
        next_synth_clock = synth_clock;
        next_background_debug = background_debug;
        if (cfg_take) begin
            next_boot_port_8bit = alt_sel(data_in, rcms_pkg::SEL_BOOT_WIDTH);
            next_arbitration_pins = alt_sel(data_in, rcms_pkg::SEL_ARBITRATION);
            next_function_code_pins = alt_sel(data_in, rcms_pkg::SEL_FUNC_CODE);
            next_addr_pins = addr_span(data_in);
            next_general_port_e = alt_sel(data_in, rcms_pkg::SEL_PORT_E);
            next_general_port_f = alt_sel(data_in, rcms_pkg::SEL_PORT_F);
            next_test_mode = alt_sel(data_in, rcms_pkg::SEL_TEST);
            next_synth_clock = clock_source_pin;
            next_background_debug = !(breakpoint_in_int && breakpoint_in);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boot_port_8bit <= 1'b0;
            arbitration_pins <= 1'b0;
            function_code_pins <= 1'b0;
            addr_pins <= 5'h00;
            general_port_e <= 1'b0;
            general_port_f <= 1'b0;
            test_mode <= 1'b0;
            synth_clock <= 1'b1;
            background_debug <= 1'b0;
        end else begin
            boot_port_8bit <= next_boot_port_8bit;
            arbitration_pins <= next_arbitration_pins;
            function_code_pins <= next_function_code_pins;
            addr_pins <= next_addr_pins;
            general_port_e <= next_general_port_e;
            general_port_f <= next_general_port_f;
            test_mode <= next_test_mode;
            synth_clock <= next_synth_clock;
            background_debug <= next_background_debug;
        end
    end
endmodule

// ==== rcms_pkg.sv ====
// Constants for the reset control and mode select block
package rcms_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // First bus cycle follows reset release by this many output-clock cycles
    localparam int unsigned FIRST_CYCLE_DELAY = 10;
    // Pin reset stretch after the outside driver lets go, output-clock cycles
    localparam int unsigned STRETCH_CYCLES = 512;
    // Data bus mode-select positions
    localparam int unsigned SEL_BOOT_WIDTH = 0;
    localparam int unsigned SEL_ARBITRATION = 1;
    localparam int unsigned SEL_FUNC_CODE = 2;
    localparam int unsigned SEL_ADDR_LO = 3;
    localparam int unsigned SEL_ADDR_HI = 7;
    localparam int unsigned SEL_PORT_E = 8;
    localparam int unsigned SEL_PORT_F = 9;
    localparam int unsigned SEL_TEST = 11;
    localparam logic [23:0] BOOT_VECTOR_ADDR = 24'h000000;
    // Reset source bits
    localparam int unsigned SRC_POWER = 0;
    localparam int unsigned SRC_WATCHDOG = 1;
    localparam int unsigned SRC_HALT = 2;
    localparam int unsigned SRC_EXTERNAL = 3;
    localparam int unsigned SRC_CLOCK_LOSS = 4;
    localparam int unsigned SRC_TEST = 5;
    localparam int unsigned SRC_INSTR = 6;
    localparam int unsigned SRC_COUNT = 7;
endpackage

// ==== rcms_stretch.sv ====
// Counter that holds a reset line for a minimum number of enabled cycles
`timescale 1ns/100ps
module rcms_stretch #(
    parameter int unsigned CYCLES = rcms_pkg::STRETCH_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic hold,
    output logic active
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    always_comb begin
        next_count = count;
        if (hold) begin
            next_count = CW'(CYCLES);
        end else if (tick && count != '0) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= CW'(CYCLES);
        end else begin
            count <= next_count;
        end
    end

    assign active = hold || (count != '0);
endmodule

// ==== rcms_properties.sv ====
// Checker for the reset control and mode select block
`timescale 1ns/100ps
module rcms_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic output_clock,
    input wire logic power_up_req,
    input wire logic watchdog_req,
    input wire logic halt_req,
    input wire logic instr_req,
    input wire logic bus_cycle_end,
    input wire logic [15:0] data_in,
    input wire logic clock_source_pin,
    input wire logic breakpoint_in_int,
    input wire logic breakpoint_in,
    input wire logic pin_reset_drive,
    input wire logic clock_unit_reset,
    input wire logic master_reset_line,
    input wire logic instruction_reset_line,
    input wire logic bus_monitor_force,
    input wire logic bus_start,
    input wire logic boot_select,
    input wire logic [23:0] boot_vector_addr,
    input wire logic boot_port_8bit,
    input wire logic test_mode,
    input wire logic synth_clock,
    input wire logic background_debug
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Rising output-clock edges since the master reset line fell
    logic oclk_q;
    logic [4:0] rise_count;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oclk_q <= 1'b0;
            rise_count <= 5'h00;
        end else begin
            oclk_q <= output_clock;
            if (master_reset_line) begin
                rise_count <= 5'h00;
            end else if (output_clock && !oclk_q && rise_count != 5'h1f) begin
                rise_count <= rise_count + 5'h01;
            end
        end
    end
    chk_async_lines: assert property ((power_up_req || watchdog_req || halt_req)
        && !master_reset_line |-> ##[1:4] (master_reset_line && clock_unit_reset && pin_reset_drive))
        else $error("async reset lines late");
    chk_instr_only: assert property ($rose(instr_req) && !master_reset_line |-> ##[1:4]
        (pin_reset_drive && instruction_reset_line && !master_reset_line && !clock_unit_reset))
        else $error("instruction reset lines wrong");
    chk_sync_wait: assert property (bus_monitor_force && !bus_cycle_end
        && !(power_up_req || watchdog_req || halt_req) |=> !master_reset_line)
        else $error("sync reset did not wait for cycle end");
    chk_stretch_min: assert property ($rose(master_reset_line) |-> master_reset_line[*4])
        else $error("reset stretch too short");
    chk_start_delay: assert property (bus_start |-> rise_count == 5'h0a)
        else $error("first bus cycle mistimed");
    chk_start_seen: assert property ($fell(master_reset_line) |-> ##[1:30] bus_start)
        else $error("first bus cycle missing");
    chk_boot_active: assert property (boot_select == !master_reset_line
        && boot_vector_addr == 24'h000000) else $error("boot select wrong");
    chk_mode_latch: assert property ($fell(master_reset_line) |-> boot_port_8bit == !data_in[0]
        && test_mode == !data_in[11] && synth_clock == clock_source_pin
        && background_debug == !(breakpoint_in && breakpoint_in_int)) else $error("mode latch wrong");
    chk_config_hold: assert property (!master_reset_line && !$past(master_reset_line) |->
        $stable({boot_port_8bit, test_mode, synth_clock, background_debug}))
        else $error("config changed while running");
    cover property ($rose(bus_monitor_force));
    cover property ($rose(instruction_reset_line));
    cover property (bus_start);
endmodule

// ==== rcms_far_side.sv ====
// Model of the outside reset source and mode-select drivers
`timescale 1ns/100ps
module rcms_far_side (
    input wire logic mclk,
    input wire logic master_reset_line,
    input wire logic bus_start,
    input wire logic ext_hold,
    input wire logic [15:0] mode_word,
    input wire logic clk_mode,
    output logic ext_reset_n,
    output logic [15:0] data_in,
    output logic clock_source_pin
);
    logic drive = 1'b1;
    // Drivers let go once the first bus cycle starts
    always_ff @(posedge mclk) begin
        if (master_reset_line) begin
            drive <= 1'b1;
        end else if (bus_start) begin
            drive <= 1'b0;
        end
    end
    assign data_in = drive ? mode_word : 16'hffff;
    assign clock_source_pin = drive ? clk_mode : ~clk_mode;
    assign ext_reset_n = ~ext_hold;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the reset control and mode select block
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, output_clock = 1'b0, bus_cycle_end = 1'b1, clk_mode = 1'b1;
    logic [1:0] bp = 2'h3;
    logic [6:0] req = 7'h00;
    logic [15:0] mode_word = 16'hffff;
    logic [31:0] seed = 32'h9d471c0f;
    int n_fail = 0, comparisons = 0;
    logic pin_reset_drive, clock_unit_reset, master_reset_line, instruction_reset_line;
    logic bus_monitor_force, bus_start, boot_select, boot_port_8bit, arbitration_pins;
    logic function_code_pins, general_port_e, general_port_f, test_mode, synth_clock;
    logic background_debug, ext_reset_n, clock_source_pin;
    logic [23:0] boot_vector_addr;
    logic [4:0] addr_pins;
    logic [15:0] data_in;
    rcms_reset_control #(.STRETCH(4)) DUT (.*, .power_up_req(req[0]), .watchdog_req(req[1]),
        .halt_req(req[2]), .clock_loss_req(req[4]), .test_req(req[5]), .instr_req(req[6]),
        .breakpoint_in_int(bp[0]), .breakpoint_in(bp[1]));
    rcms_far_side far (.mclk(mclk), .master_reset_line(master_reset_line), .bus_start(bus_start),
        .ext_hold(req[3]), .mode_word(mode_word), .clk_mode(clk_mode), .ext_reset_n(ext_reset_n),
        .data_in(data_in), .clock_source_pin(clock_source_pin));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [12:0] cfg_exp(input logic [15:0] w, input logic cm, input logic [1:0] b);
        logic [4:0] a;
        a = 5'h00;
        for (int k = 0; k < 5; k++) begin
            if (!w[3 + k]) begin
                a = 5'h1f >> (4 - k);
            end
        end
        return {!w[0], !w[1], !w[2], a, !w[8], !w[9], !w[11], cm, !(b[0] && b[1])};
    endfunction
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic wait_sig(input logic sel, input logic v);
        int n;
        n = 0;
        while ((sel ? pin_reset_drive : bus_start) !== v) begin
            step(1);
            n++;
            if (n > 200) begin
                chk(1'b0, "wait timed out");
                end_sim();
            end
        end
    endtask
    task automatic run_src(input int s, input logic [15:0] w);
        logic [31:0] r;
        logic sync;
        r = rnd();
        sync = s >= 3 && s <= 5;
        mode_word = w;
        clk_mode = r[0];
        bp = r[2:1];
        bus_cycle_end = !sync;
        req[s] = 1'b1;
        if (sync) begin
            step(6);
            chk(master_reset_line === 1'b0 && bus_monitor_force === 1'b1, "no wait");
            bus_cycle_end = 1'b1;
        end
        wait_sig(1'b1, 1'b1);
        step(3);
        chk({pin_reset_drive, clock_unit_reset, master_reset_line, instruction_reset_line} ===
            (s == 6 ? 4'h9 : s == 5 ? 4'ha : 4'he), "reset lines");
        req = 7'h00;
        if (s == 6) begin
            wait_sig(1'b1, 1'b0);
        end else begin
            wait_sig(1'b0, 1'b1);
            chk({boot_port_8bit, arbitration_pins, function_code_pins, addr_pins, general_port_e,
                general_port_f, test_mode, synth_clock, background_debug} === cfg_exp(w, r[0], r[2:1]),
                "mode config");
            chk(boot_select === 1'b1 && boot_vector_addr === 24'h000000, "boot");
        end
        step(4);
    endtask
    initial begin
        forever #20 mclk = ~mclk;
    end
    always begin
        @(posedge mclk);
        #2;
        output_clock = ~output_clock;
    end
    initial begin
        step(20);
        chk({pin_reset_drive, clock_unit_reset, master_reset_line} === 3'h7, "reset hold");
        rst_n = 1'b1;
        wait_sig(1'b0, 1'b1);
        for (int i = 0; i < 16; i++) begin
            run_src(i % 7, i == 0 ? 16'hffff : i == 1 ? 16'h0000 : 16'(rnd()));
        end
        end_sim();
    end
endmodule
bind rcms_reset_control rcms_props u_props (.*);
